//--- rtl/stepper_params.svh
// Constants for the stepper pulse sequencer
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_START 8'h00
`define OFS_STATUS 8'h04
`define OFS_CMPA 8'h08
`define OFS_TIMER 8'h0c
`define OFS_OUTPUT 8'h10
`define OFS_STEPS 8'h14
`define OFS_STOPWORD 8'h18
`define OFS_PERIOD0 8'h20
`define OFS_PATTERN0 8'h40
// ------------------------------------------------------------
// Reset and setup values
// ------------------------------------------------------------
`define MODE_RST 3'h1
`define POD_RST 8'h09
`define NDE_VAL 8'h0f
`define PCR_VAL 8'he4
`define PMR_VAL 8'hff
`define NDR_RST 8'hfc
`define CNT_RST 16'h0065
`define CMPA_RST 16'h0064
`define CMPB_RST 16'hff00
`define TIER_VAL 8'h41
`define ACT_RST 8'h20
`define START_VAL 8'h01
`define FLAG_A_CLR 8'hfe
`define PAT_CNT 16'h0404
`define ACCEL_RST 4'h8
`define CRUISE_RST 8'h10
`define STOP_CNT_RST 8'h04
`define STOP_WORD_RST 16'h8000
// ------------------------------------------------------------
// Transfer mode values and field positions
// ------------------------------------------------------------
`define XM_PAT_FWD 8'h86
`define XM_PAT_REV 8'hc6
`define XM_PAT_STOP 8'h06
`define XM_PER_UP 8'h81
`define XM_PER_CONST 8'h01
`define XM_PER_DOWN 8'hc1
`define XM_PER_STOP 8'h10
`define SM_INC 2'b10
`define SM_DEC 2'b11
`define SM_FIX 2'b00
`define ACT_BIT 5
`define TIER_A_BIT 0
`define PMR_NOV_BIT 0
`define PMR_INV_BIT 4
`define PAT_LAST 2'h3
`define MODE_STOP_F 3'h3
`define MODE_STOP_R 3'h7
`endif

//--- rtl/stepper_pkg.sv
// Types for the stepper pulse sequencer
package stepper_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_PAT, ST_PER, ST_SVC} xfer_state_t;
	typedef struct packed {
		logic [7:0] xmode;
		logic [2:0] src;
		logic [7:0] count;
		logic from_stop;
	} descriptor_t;
endpackage

//--- rtl/stepper_pulse_sequencer.sv
// Stepper pulse sequencer with compare timer, chained transfers and mode sequencer
//
// Overview of operation
// RL1: Mode selector resets to forward constant, one.
// RL2: Forward modes advance 0,1,2,3 per run.
// RL3: Forward stop goes to reverse 4..7.
// RL4: Reverse stop wraps to forward speed-up 0.
// RL5: Service re-arms activation bit 5, clears flag A.
// RL6: Output data starts at pattern 09.
// RL7: Next-data enable 0F, only bits 3..0.
// RL8: Output trigger is channel 0 compare match.
// RL9: Direct output and non-overlap for all groups.
// RL10: Next-data preloaded with FC before start.
// RL11: Timer count preloaded with 0065.
// RL12: Forward pattern source is table entry 0.
// RL13: Mode 86: incrementing repeat byte source.
// RL14: Pattern counts 0404: repeat four, count four.
// RL15: Speed-up period source entry 0, mode 81.
// RL16: Period word goes to compare B.
// RL17: Compare B starts at FF00.
// RL18: Timer enable 41 lets flag A request.
// RL19: Counting starts only on start write 01.
// RL20: Slow-down period from last entry, mode C1.
// RL21: Constant speed holds last entry, cruise count.
// RL22: Reverse pattern from entry 3, mode C6.
// RL23: Trigger copies only enabled next-data bits.
// RL24: Mode codes: 0-2 fwd, 3 stop, 4-6 rev, 7 stop.
// RL25: Pattern then period per match; reload at zero.
// RL26: Stop modes hold pattern, repeat stop word.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "stepper_params.svh"
`default_nettype none
module stepper_pulse_sequencer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [3:0] pulse_o,
	output logic [2:0] mode_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	stepper_pkg::xfer_state_t state_r;
	stepper_pkg::descriptor_t pat_r, per_r, pat_nxt, per_nxt;
	logic [2:0] motor_mode_selector_r;
	logic [7:0] pulse_output_data_r, next_pattern_data_r;
	logic [7:0] transfer_activation_enable_r, timer_flag_status_r;
	logic [7:0] pat_rpt_r;
	logic [15:0] timer_count_r, compare_a_r, compare_b_register_r, stop_word_r;
	logic timer_start_control_r;
	logic [3:0] accel_step_count_r;
	logic [7:0] cruise_step_count_r, stop_count_r;
	logic [15:0] period_tbl_r [0:7];
	logic [7:0] pattern_tbl_r [0:3];
	logic [31:0] rdata_nxt;
	// ------------------------------------------------------------
	// Fixed register settings
	// ------------------------------------------------------------
	localparam logic [7:0] TIER_SET = `TIER_VAL;
	localparam logic [7:0] PCR_SET = `PCR_VAL;
	localparam logic [7:0] PMR_SET = `PMR_VAL;
	localparam logic [15:0] PAT_COUNTS = `PAT_CNT;
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic bus_wr = bus_req && wb_we_i;
	wire logic [7:0] ofs = {wb_adr_i[7:2], 2'b00};
	wire logic [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire logic in_period = (ofs >= `OFS_PERIOD0) && (ofs < `OFS_PATTERN0);
	wire logic in_pattern = (ofs >= `OFS_PATTERN0) && (ofs < (`OFS_PATTERN0 + 8'h10));
	wire logic [2:0] per_sel = wb_adr_i[4:2];
	wire logic [1:0] pat_sel = wb_adr_i[3:2];
	wire logic [2:0] last_period = 3'(accel_step_count_r - 4'h1);
	wire logic cmpa_match = timer_start_control_r && (timer_count_r == compare_a_r);
	wire logic cmpb_match = timer_start_control_r && (timer_count_r == compare_b_register_r);
	wire logic xfer_go = cmpa_match && TIER_SET[`TIER_A_BIT]
		&& transfer_activation_enable_r[`ACT_BIT] && (state_r == stepper_pkg::ST_IDLE); // see RL18
	wire logic [7:0] enabled_next = next_pattern_data_r & `NDE_VAL; // see RL7
	wire logic [1:0] pat_idx = pat_r.src[1:0];
	wire logic [2:0] pat_restart = (pat_r.xmode[7:6] == `SM_DEC) ? {1'b0, `PAT_LAST}
		: ((pat_r.xmode[7:6] == `SM_INC) ? 3'h0 : pat_r.src); // see RL26
	wire logic [15:0] per_word = per_r.from_stop ? stop_word_r : period_tbl_r[per_r.src];
	wire logic pat_last = (pat_r.count <= 8'h01);
	wire logic per_last = (per_r.count <= 8'h01);
	wire logic [2:0] mode_next = 3'(motor_mode_selector_r + 3'h1); // see RL2 RL3 RL4
	wire logic reverse = motor_mode_selector_r[2]; // see RL24
	wire logic is_stop = (motor_mode_selector_r == `MODE_STOP_F)
		|| (motor_mode_selector_r == `MODE_STOP_R); // see RL24
	// ------------------------------------------------------------
	// Descriptor reload for the current mode
	// ------------------------------------------------------------
	always_comb begin
		pat_nxt = '0;
		per_nxt = '0;
		pat_nxt.count = PAT_COUNTS[7:0]; // see RL14
		if (is_stop) begin
			pat_nxt.src = {1'b0, `PAT_LAST};
			pat_nxt.xmode = `XM_PAT_STOP;
			per_nxt.from_stop = 1'b1;
			per_nxt.xmode = `XM_PER_STOP;
			per_nxt.count = stop_count_r; // see RL26
		end else begin
			pat_nxt.src = reverse ? {1'b0, `PAT_LAST} : 3'h0; // see RL12 RL22
			pat_nxt.xmode = reverse ? `XM_PAT_REV : `XM_PAT_FWD; // see RL13 RL22
			case (motor_mode_selector_r[1:0])
				2'h0: begin
					per_nxt.src = 3'h0;
					per_nxt.xmode = `XM_PER_UP; // see RL15
					per_nxt.count = {4'h0, accel_step_count_r};
				end
				2'h1: begin
					per_nxt.src = last_period;
					per_nxt.xmode = `XM_PER_CONST;
					per_nxt.count = cruise_step_count_r; // see RL21
				end
				default: begin
					per_nxt.src = last_period;
					per_nxt.xmode = `XM_PER_DOWN; // see RL20
					per_nxt.count = {4'h0, accel_step_count_r};
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// Timer channel
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_count_r <= `CNT_RST; // see RL11
			timer_start_control_r <= 1'b0;
		end else begin
			if (bus_wr && ofs == `OFS_START && wb_sel_i[0])
				timer_start_control_r <= (wb_dat_i[7:0] == `START_VAL); // see RL19
			if (timer_start_control_r)
				timer_count_r <= cmpb_match ? 16'h0000 : 16'(timer_count_r + 16'h0001);
		end
	end
	// ------------------------------------------------------------
	// Flags and activation enable
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_flag_status_r <= 8'h00;
			transfer_activation_enable_r <= `ACT_RST;
		end else begin
			if (state_r == stepper_pkg::ST_SVC) begin
				transfer_activation_enable_r[`ACT_BIT] <= 1'b1; // see RL5
				timer_flag_status_r <= (timer_flag_status_r & `FLAG_A_CLR)
					| {6'h00, cmpb_match, cmpa_match}; // see RL5
			end else begin
				if (state_r == stepper_pkg::ST_PER && per_last)
					transfer_activation_enable_r[`ACT_BIT] <= 1'b0;
				timer_flag_status_r <= timer_flag_status_r | {6'h00, cmpb_match, cmpa_match};
			end
		end
	end
	// ------------------------------------------------------------
	// Pulse output group
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_output_data_r <= `POD_RST; // see RL6
		end else if (cmpb_match && PCR_SET[1:0] == 2'b00) begin
			pulse_output_data_r <= (pulse_output_data_r & ~`NDE_VAL) | enabled_next; // see RL23 RL8
		end else if (cmpa_match && PMR_SET[`PMR_NOV_BIT]) begin
			pulse_output_data_r <= pulse_output_data_r & ~(`NDE_VAL & ~next_pattern_data_r); // see RL9
		end
	end
	// ------------------------------------------------------------
	// Transfer engine and mode sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= stepper_pkg::ST_IDLE;
			motor_mode_selector_r <= `MODE_RST; // see RL1
			next_pattern_data_r <= `NDR_RST; // see RL10
			compare_b_register_r <= `CMPB_RST; // see RL17
			pat_rpt_r <= PAT_COUNTS[15:8];
			pat_r <= '{xmode: `XM_PAT_FWD, src: 3'h0, count: PAT_COUNTS[7:0], from_stop: 1'b0};
			per_r <= '{xmode: `XM_PER_UP, src: 3'h0, count: {4'h0, `ACCEL_RST}, from_stop: 1'b0};
		end else begin
			case (state_r)
				stepper_pkg::ST_IDLE: begin
					if (xfer_go)
						state_r <= stepper_pkg::ST_PAT; // see RL25
				end
				stepper_pkg::ST_PAT: begin
					next_pattern_data_r <= pattern_tbl_r[pat_idx];
					if (pat_last) begin
						pat_r.count <= pat_rpt_r;
						pat_r.src <= pat_restart; // see RL26
					end else begin
						pat_r.count <= 8'(pat_r.count - 8'h01);
						if (pat_r.xmode[7:6] == `SM_INC)
							pat_r.src <= {1'b0, 2'(pat_idx + 2'h1)};
						else if (pat_r.xmode[7:6] == `SM_DEC)
							pat_r.src <= {1'b0, 2'(pat_idx - 2'h1)};
					end
					state_r <= stepper_pkg::ST_PER; // see RL25
				end
				stepper_pkg::ST_PER: begin
					compare_b_register_r <= per_word; // see RL16
					per_r.count <= 8'(per_r.count - 8'h01);
					if (per_r.xmode[7:6] == `SM_INC)
						per_r.src <= 3'(per_r.src + 3'h1);
					else if (per_r.xmode[7:6] == `SM_DEC)
						per_r.src <= 3'(per_r.src - 3'h1);
					state_r <= per_last ? stepper_pkg::ST_SVC : stepper_pkg::ST_IDLE; // see RL25
				end
				stepper_pkg::ST_SVC: begin
					pat_r <= pat_nxt;
					per_r <= per_nxt;
					pat_rpt_r <= PAT_COUNTS[15:8];
					motor_mode_selector_r <= mode_next; // see RL2 RL3 RL4
					state_r <= stepper_pkg::ST_IDLE;
				end
				default: state_r <= stepper_pkg::ST_IDLE;
			endcase
		end
	end
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_a_r <= `CMPA_RST;
			stop_word_r <= `STOP_WORD_RST;
			accel_step_count_r <= `ACCEL_RST;
			cruise_step_count_r <= `CRUISE_RST;
			stop_count_r <= `STOP_CNT_RST;
			for (int i = 0; i < 8; i++)
				period_tbl_r[i] <= `CMPB_RST;
			for (int i = 0; i < 4; i++)
				pattern_tbl_r[i] <= `NDR_RST;
		end else if (bus_wr) begin
			if (ofs == `OFS_CMPA)
				compare_a_r <= (compare_a_r & ~wmask) | (wb_dat_i[15:0] & wmask);
			if (ofs == `OFS_STOPWORD)
				stop_word_r <= (stop_word_r & ~wmask) | (wb_dat_i[15:0] & wmask);
			if (ofs == `OFS_STEPS && wb_sel_i[0])
				accel_step_count_r <= wb_dat_i[3:0];
			if (ofs == `OFS_STEPS && wb_sel_i[1])
				cruise_step_count_r <= wb_dat_i[15:8];
			if (ofs == `OFS_STEPS && wb_sel_i[2])
				stop_count_r <= wb_dat_i[23:16];
			if (in_period)
				period_tbl_r[per_sel] <= (period_tbl_r[per_sel] & ~wmask) | (wb_dat_i[15:0] & wmask);
			if (in_pattern && wb_sel_i[0])
				pattern_tbl_r[pat_sel] <= wb_dat_i[7:0];
		end
	end
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (in_period)
			rdata_nxt = {16'h0000, period_tbl_r[per_sel]};
		else if (in_pattern)
			rdata_nxt = {24'h00_0000, pattern_tbl_r[pat_sel]};
		else begin
			case (ofs)
				`OFS_START: rdata_nxt = {31'h0, timer_start_control_r};
				`OFS_STATUS: rdata_nxt = {8'h00, transfer_activation_enable_r,
					timer_flag_status_r, 3'h0, state_r, motor_mode_selector_r};
				`OFS_CMPA: rdata_nxt = {16'h0000, compare_a_r};
				`OFS_TIMER: rdata_nxt = {compare_b_register_r, timer_count_r};
				`OFS_OUTPUT: rdata_nxt = {`PMR_VAL, `PCR_VAL, next_pattern_data_r,
					pulse_output_data_r};
				`OFS_STEPS: rdata_nxt = {8'h00, stop_count_r, cruise_step_count_r,
					4'h0, accel_step_count_r};
				`OFS_STOPWORD: rdata_nxt = {16'h0000, stop_word_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			pulse_o <= 4'h0;
			mode_o <= 3'h0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rdata_nxt : 32'h0000_0000;
			pulse_o <= PMR_SET[`PMR_INV_BIT] ? pulse_output_data_r[3:0]
				: ~pulse_output_data_r[3:0]; // see RL9
			mode_o <= motor_mode_selector_r;
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence seq_chain;
		state_r == stepper_pkg::ST_PAT ##1 state_r == stepper_pkg::ST_PER;
	endsequence
	sequence seq_service;
		state_r == stepper_pkg::ST_PER && per_last ##1 state_r == stepper_pkg::ST_SVC;
	endsequence
	AST_RESET_INIT: assert property (@(posedge clk_i) rst_i |=> motor_mode_selector_r == 3'h1 // see RL1
		&& pulse_output_data_r == 8'h09 && next_pattern_data_r == 8'hfc
		&& timer_count_r == 16'h0065 && compare_b_register_r == 16'hff00)
		else $error("reset values wrong");
	AST_MODE_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL2
		seq_service |=> motor_mode_selector_r == 3'($past(motor_mode_selector_r, 1) + 3'h1))
		else $error("mode did not advance by one");
	AST_MODE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL4
		state_r == stepper_pkg::ST_SVC && motor_mode_selector_r == 3'h7
		|=> motor_mode_selector_r == 3'h0)
		else $error("mode did not wrap to zero");
	AST_REV_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
		state_r == stepper_pkg::ST_SVC && motor_mode_selector_r == 3'h3
		|=> motor_mode_selector_r == 3'h4 && per_r.from_stop)
		else $error("stop did not lead to reverse");
	AST_REARM: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
		seq_service |=> transfer_activation_enable_r[5] && state_r == stepper_pkg::ST_IDLE)
		else $error("activation not re-armed");
	AST_CHAIN: assert property (@(posedge clk_i) disable iff (rst_i) // see RL25
		xfer_go |=> seq_chain)
		else $error("pattern then period chain broken");
	AST_PERIOD_DEST: assert property (@(posedge clk_i) disable iff (rst_i) // see RL16
		state_r == stepper_pkg::ST_PER |=> compare_b_register_r == $past(per_word))
		else $error("period word not in compare B");
	AST_OUT_MASK: assert property (@(posedge clk_i) disable iff (rst_i) // see RL23
		cmpb_match |=> pulse_output_data_r[7:4] == $past(pulse_output_data_r[7:4])
		&& pulse_output_data_r[3:0] == $past(next_pattern_data_r[3:0]))
		else $error("output update not masked");
	AST_HOLD_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i) // see RL19
		!timer_start_control_r |=> $stable(timer_count_r))
		else $error("counter moved before start");
	AST_REV_PATTERN: assert property (@(posedge clk_i) disable iff (rst_i) // see RL22
		state_r == stepper_pkg::ST_SVC && motor_mode_selector_r[2] && !is_stop
		|=> pat_r.src == 3'h3 && pat_r.xmode == 8'hc6)
		else $error("reverse pattern descriptor wrong");
	AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // see RL5
		state_r == stepper_pkg::ST_SVC && !cmpa_match |=> !timer_flag_status_r[0])
		else $error("flag A not cleared by service");
	AST_FWD_PATTERN: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12 RL13 RL14
		state_r == stepper_pkg::ST_SVC && !motor_mode_selector_r[2] && !is_stop
		|=> pat_r.src == 3'h0 && pat_r.xmode == `XM_PAT_FWD
		&& pat_r.count == PAT_COUNTS[7:0])
		else $error("forward pattern descriptor wrong");
	AST_ACCEL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL15
		state_r == stepper_pkg::ST_SVC && motor_mode_selector_r[1:0] == 2'h0
		|=> per_r.src == 3'h0 && per_r.xmode == `XM_PER_UP
		&& per_r.count == {4'h0, accel_step_count_r})
		else $error("speed-up period descriptor wrong");
	AST_CRUISE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
		state_r == stepper_pkg::ST_SVC && motor_mode_selector_r[1:0] == 2'h1
		|=> per_r.src == 3'(accel_step_count_r - 4'h1)
		&& per_r.count == cruise_step_count_r)
		else $error("constant speed descriptor wrong");
	AST_SLOW_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL20
		state_r == stepper_pkg::ST_SVC && motor_mode_selector_r[1:0] == 2'h2
		|=> per_r.src == 3'(accel_step_count_r - 4'h1) && per_r.xmode == `XM_PER_DOWN
		&& per_r.count == {4'h0, accel_step_count_r})
		else $error("slow-down period descriptor wrong");
	AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL26
		state_r == stepper_pkg::ST_PAT && pat_r.xmode[7:6] == `SM_FIX
		|=> pat_r.src == $past(pat_r.src))
		else $error("stop pattern source moved");
	AST_STOP_WORD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL26
		state_r == stepper_pkg::ST_PER && per_r.from_stop |=> compare_b_register_r == stop_word_r)
		else $error("stop word not in compare B");
	AST_OUT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL23
		!cmpa_match && !cmpb_match |=> $stable(pulse_output_data_r))
		else $error("output data changed without trigger");
	AST_NONOVERLAP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL9
		cmpa_match && !cmpb_match
		|=> (pulse_output_data_r & ~$past(pulse_output_data_r)) == 8'h00)
		else $error("non-overlap set an output bit");
	AST_PIN_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i) // see RL9
		1'b1 |=> pulse_o == $past(pulse_output_data_r[3:0]))
		else $error("pins not a direct copy of output data");
endmodule
`default_nettype wire

//--- dv/motor_stage_model.sv
// Motor driver stage model that counts phase steps seen on the pulse pins
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] phase_i,
	output logic [15:0] fwd_steps_o,
	output logic [15:0] rev_steps_o
);
	// ------------------------------------------------------------
	// Phase tracking
	// ------------------------------------------------------------
	logic [3:0] last_r;
	wire one_hot = (phase_i != 4'h0) && ((phase_i & (phase_i - 4'h1)) == 4'h0);

	// Non-overlap gaps are not one-hot and leave the rotor where it was
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_r <= 4'h0;
			fwd_steps_o <= 16'h0000;
			rev_steps_o <= 16'h0000;
		end else if (one_hot && phase_i != last_r) begin
			last_r <= phase_i;
			if (phase_i == {last_r[2:0], last_r[3]}) begin
				fwd_steps_o <= fwd_steps_o + 16'h0001;
			end else if (phase_i == {last_r[0], last_r[3:1]}) begin
				rev_steps_o <= rev_steps_o + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/test_stepper_pulse_sequencer.sv
// Self-checking bench for the stepper pulse sequencer
`timescale 1ns/1ps
`include "stepper_params.svh"
`default_nettype none
module test_stepper_pulse_sequencer;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
	} read_note_t;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mode_watch;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i, pulse_o;
	logic [2:0] mode_o, last_mode;
	logic [15:0] fwd_steps, rev_steps, seed;
	logic [2:0] mode_seq [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
	read_note_t rd_q[$];
	read_note_t note;
	logic [2:0] mode_q[$];
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;

	stepper_pulse_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulse_o(pulse_o),
		.mode_o(mode_o));
	motor_stage_model motor (.clk_i(clk_i), .rst_i(rst_i), .phase_i(pulse_o),
		.fwd_steps_o(fwd_steps), .rev_steps_o(rev_steps));

	// ------------------------------------------------------------
	// Clock, timeout and report
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("[FAIL] %0t run did not complete", $time);
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Compare tasks and result watchers
	// ------------------------------------------------------------
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
		input logic [31:0] mask);
		checked++;
		if ((got & mask) !== (exp & mask)) begin
			num_errors++;
			$display("[FAIL] %0t value %h expected %h mask %h", $time, got, exp, mask);
		end
	endtask

	task automatic cmp_mode(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t mode %h expected %h", $time, got, exp);
		end
	endtask

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
			note = rd_q.pop_front();
			cmp_word(wb_dat_o, note.exp, note.mask);
		end
		if (mode_watch && mode_o !== last_mode) begin
			last_mode = mode_o;
			if (mode_q.size() == 0) begin
				cmp_mode(mode_o, 3'bxxx);
			end else begin
				cmp_mode(mode_o, mode_q.pop_front());
			end
		end
	end

	// ------------------------------------------------------------
	// Bus master
	// ------------------------------------------------------------
	task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {24'h000000, adr};
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			$display("[FAIL] %0t no bus answer", $time);
		end
	endtask

	task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
		wb_cycle(adr, 1'b1, dat);
	endtask

	task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp,
		input logic [31:0] mask);
		rd_q.push_back('{exp, mask});
		wb_cycle(adr, 1'b0, 32'h00000000);
	endtask

	function automatic logic [15:0] xs(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 32'h00000000;
		wb_dat_i = 32'h00000000;
		wb_sel_i = 4'hf;
		mode_watch = 1'b0;
		last_mode = 3'h1;
		seed = 16'heedd;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		cmp_word({28'h0000000, pulse_o}, 32'h00000009, 32'h0000000f);
		cmp_mode(mode_o, 3'h1);
		mode_watch = 1'b1;
		rd_check(`OFS_OUTPUT, 32'hffe4fc09, 32'hffffffff);
		rd_check(`OFS_TIMER, 32'hff000065, 32'hffffffff);
		rd_check(`OFS_STATUS, 32'h00200001, 32'h00ff0007);
		wb_write(8'hf0, 32'hffffffff);
		rd_check(8'hf0, 32'h00000000, 32'hffffffff);
		wb_write(`OFS_TIMER, 32'h00000000);
		repeat (20) @(posedge clk_i);
		rd_check(`OFS_TIMER, 32'hff000065, 32'hffffffff);
		wb_write(`OFS_CMPA, 32'h00000066);
		wb_write(`OFS_STEPS, 32'h00050202);
		wb_write(`OFS_STOPWORD, 32'h00000090);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			wb_write(`OFS_PERIOD0 + 8'(4 * i), {16'h0000, 16'h0080 + (seed & 16'h001f)});
		end
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			wb_write(`OFS_PATTERN0 + 8'(4 * i), {24'h000000, seed[7:4], 4'(1 << i)});
		end
		foreach (mode_seq[i]) mode_q.push_back(mode_seq[i]);
		wb_write(`OFS_START, 32'h00000001);
		while (mode_q.size() != 0) @(posedge clk_i);
		rd_check(`OFS_OUTPUT, 32'hffe40000, 32'hffff00f0);
		rd_check(`OFS_STATUS, 32'h00000200, 32'h00000200);
		cmp_word({31'h0, |fwd_steps}, 32'h00000001, 32'h00000001);
		cmp_word({31'h0, |rev_steps}, 32'h00000001, 32'h00000001);
		wb_write(`OFS_START, 32'h00000000);
		repeat (4) @(posedge clk_i);
		final_report();
	end
endmodule
`default_nettype wire
